/* File: wakeup_ctrl_regs.vh */
/*
 Register offsets, field positions, reset values and timing counts for the
 sleep, wake-up and general-purpose pin controller.
 Assumes inclusion by bare name from the same folder.
*/
`ifndef WAKEUP_CTRL_REGS_VH
`define WAKEUP_CTRL_REGS_VH

`define REG_MISC_CTRL       4'h0
`define REG_PORTA_DATA      4'h1
`define REG_PORTA_DIR       4'h2
`define REG_PORTA_PULLUP    4'h3
`define REG_PORTA_PULLDN    4'h4
`define REG_PORTA_DIEN      4'h5
`define REG_PORTB_DATA      4'h6
`define REG_PORTB_DIR       4'h7
`define REG_PORTB_PULLUP    4'h8
`define REG_PORTB_PULLDN    4'h9
`define REG_PORTB_DIEN      4'ha
`define REG_CMP_CONTROL     4'hb
`define REG_CMP_SELECT      4'hc
`define REG_POWER_CMD       4'hd
`define REG_POWER_STATUS    4'he

`define MISC_FAST_WAKE_BIT  5
`define CMP_ENABLE_BIT      7
`define CMP_WAKE_SEL_BIT    6
`define CMD_LIGHT_BIT       0
`define CMD_DEEP_BIT        1

`define MISC_RESET          8'h00
`define PORT_RESET          8'h00
`define DIEN_RESET          8'hff
`define CMP_RESET           8'h00

`define WAKE_NORMAL_LRC     12'd3000
`define WAKE_FAST_LRC       12'd45

`endif

/* File: wakeup_ctrl.v */
/*
 Sleep-mode, wake-up timing and general-purpose pin controller.
 Assumes: clk is the always-on 25 MHz control clock; lrc_clk_in is the
 low-speed RC oscillator output arriving asynchronously; the core obeys
 core_halt and program_memory_power; reset causes arrive as level inputs.
*/
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "wakeup_ctrl_regs.vh"

module wakeup_ctrl #(
    parameter PINS_A = 8,
    parameter PINS_B = 8,
    parameter LOW_VOLTAGE_LEVEL_SEL = 3
) (
    // Clock and reset
    input  wire              clk,
    input  wire              rst,
    input  wire              ce,
    // Register port
    input  wire [3:0]        addr,
    input  wire [7:0]        wdata,
    input  wire              wr,
    input  wire              rd,
    output reg  [7:0]        rdata,
    // Configuration options and reset causes
    input  wire              fast_boot_opt,
    input  wire              ext_reset_cause,
    input  wire              watchdog_reset_cause,
    input  wire              power_on_cause,
    input  wire              low_voltage_reset,
    output wire [2:0]        low_voltage_reset_level,
    // Wake events and oscillator
    input  wire              timer_event,
    input  wire              cmp_event,
    input  wire              lrc_clk_in,
    // Power controls
    output wire              low_speed_rc_osc_en,
    output wire              high_speed_rc_osc_en,
    output wire              external_crystal_osc_en,
    output wire              sys_clk_en,
    output wire              core_halt,
    output wire              program_memory_power,
    output wire              sram_clear,
    output wire              core_restart,
    // Pins
    input  wire [PINS_A-1:0] porta_in,
    output wire [PINS_A-1:0] porta_out,
    output wire [PINS_A-1:0] porta_oe,
    output wire [PINS_A-1:0] porta_pu,
    output wire [PINS_A-1:0] porta_pd,
    input  wire [PINS_B-1:0] portb_in,
    output wire [PINS_B-1:0] portb_out,
    output wire [PINS_B-1:0] portb_oe,
    output wire [PINS_B-1:0] portb_pu,
    output wire [PINS_B-1:0] portb_pd
);
    localparam NP = PINS_A + PINS_B;
    localparam ST_RUN   = 2'd0;
    localparam ST_LIGHT = 2'd1;
    localparam ST_DEEP  = 2'd2;
    localparam ST_WAKE  = 2'd3;

    reg [7:0]    misc_q;
    reg [7:0]    cmp_ctl_q;
    reg [7:0]    cmp_sel_q;
    reg [NP-1:0] data_q;
    reg [NP-1:0] dir_q;
    reg [NP-1:0] pu_q;
    reg [NP-1:0] pd_q;
    reg [NP-1:0] dien_q;
    reg [1:0]    state_q;
    reg          deep_q;
    reg          any_rst_q;
    reg          sram_clr_q;
    reg [NP-1:0] pin_s1_q;
    reg [NP-1:0] pin_s2_q;
    reg [NP-1:0] pin_s3_q;
    reg [NP-1:0] pin_stable_q;
    reg          lrc_s1_q;
    reg          lrc_s2_q;
    reg          lrc_s3_q;
    reg          lrc_lvl_q;
    reg [11:0]   wake_cnt_q;
    reg [11:0]   wake_target_q;
    reg [7:0]    rd_d;

    wire [NP-1:0] pad_in = {portb_in, porta_in};
    wire [NP-1:0] pin_agree = ~(pin_s2_q ^ pin_s3_q);
    wire [NP-1:0] pin_next = (pin_agree & pin_s2_q) | (~pin_agree & pin_stable_q);
    wire          lrc_agree = (lrc_s2_q == lrc_s3_q);
    wire          lrc_rise = lrc_agree & lrc_s2_q & ~lrc_lvl_q;
    // Toggle counts only on input-mode pins with their digital input enabled
    wire          pin_wake = |((pin_next ^ pin_stable_q) & dien_q & ~dir_q);
    wire          cmp_wake = cmp_event & cmp_ctl_q[`CMP_ENABLE_BIT]
                             & cmp_sel_q[`CMP_WAKE_SEL_BIT];
    wire          light_wake = pin_wake | timer_event | cmp_wake;
    wire          fast_sel = fast_boot_opt | misc_q[`MISC_FAST_WAKE_BIT];
    wire [11:0]   target_d = fast_sel ? `WAKE_FAST_LRC : `WAKE_NORMAL_LRC;
    wire          reg_wr = wr & ce & (state_q == ST_RUN);

    // Only the power-on reset clears the data memory; pin, watchdog and low-voltage resets keep it
    always @(posedge clk)
    begin
        if (rst)
        begin
            any_rst_q  <= 1'b0;
            sram_clr_q <= 1'b0;
        end
        else if (ce)
        begin
            any_rst_q  <= ext_reset_cause | watchdog_reset_cause
                          | power_on_cause | low_voltage_reset;
            sram_clr_q <= power_on_cause;
        end
    end

    always @(posedge clk)
    begin
        if (rst)
        begin
            pin_s1_q     <= {NP{1'b0}};
            pin_s2_q     <= {NP{1'b0}};
            pin_s3_q     <= {NP{1'b0}};
            pin_stable_q <= {NP{1'b0}};
            lrc_s1_q     <= 1'b0;
            lrc_s2_q     <= 1'b0;
            lrc_s3_q     <= 1'b0;
            lrc_lvl_q    <= 1'b0;
        end
        else if (ce)
        begin
            pin_s1_q     <= pad_in;
            pin_s2_q     <= pin_s1_q;
            pin_s3_q     <= pin_s2_q;
            pin_stable_q <= pin_next;
            lrc_s1_q     <= lrc_clk_in;
            lrc_s2_q     <= lrc_s1_q;
            lrc_s3_q     <= lrc_s2_q;
            if (lrc_agree)
                lrc_lvl_q <= lrc_s2_q;
        end
    end

    // Registers are only reloaded by reset, never by sleep or wake
    always @(posedge clk)
    begin
        if (rst || (ce && any_rst_q))
        begin
            misc_q    <= `MISC_RESET;
            cmp_ctl_q <= `CMP_RESET;
            cmp_sel_q <= `CMP_RESET;
            data_q    <= {NP{1'b0}};
            dir_q     <= {NP{1'b0}};
            pu_q      <= {NP{1'b0}};
            pd_q      <= {NP{1'b0}};
            dien_q    <= {NP{1'b1}};
        end
        else if (reg_wr)
        begin
            case (addr)
                `REG_MISC_CTRL:    misc_q <= wdata;
                `REG_CMP_CONTROL:  cmp_ctl_q <= wdata;
                `REG_CMP_SELECT:   cmp_sel_q <= wdata;
                `REG_PORTA_DATA:   data_q[PINS_A-1:0] <= wdata[PINS_A-1:0];
                `REG_PORTA_DIR:    dir_q[PINS_A-1:0] <= wdata[PINS_A-1:0];
                `REG_PORTA_PULLUP: pu_q[PINS_A-1:0] <= wdata[PINS_A-1:0];
                `REG_PORTA_PULLDN: pd_q[PINS_A-1:0] <= wdata[PINS_A-1:0];
                `REG_PORTA_DIEN:   dien_q[PINS_A-1:0] <= wdata[PINS_A-1:0];
                `REG_PORTB_DATA:   data_q[NP-1:PINS_A] <= wdata[PINS_B-1:0];
                `REG_PORTB_DIR:    dir_q[NP-1:PINS_A] <= wdata[PINS_B-1:0];
                `REG_PORTB_PULLUP: pu_q[NP-1:PINS_A] <= wdata[PINS_B-1:0];
                `REG_PORTB_PULLDN: pd_q[NP-1:PINS_A] <= wdata[PINS_B-1:0];
                `REG_PORTB_DIEN:   dien_q[NP-1:PINS_A] <= wdata[PINS_B-1:0];
                default:           misc_q <= misc_q;
            endcase
        end
    end

    always @(posedge clk)
    begin
        if (rst || (ce && any_rst_q))
        begin
            state_q       <= ST_RUN;
            deep_q        <= 1'b0;
            wake_cnt_q    <= 12'h000;
            wake_target_q <= `WAKE_NORMAL_LRC;
        end
        else if (ce)
        begin
            case (state_q)
                ST_RUN:
                    if (reg_wr && addr == `REG_POWER_CMD)
                    begin
                        if (wdata[`CMD_DEEP_BIT])
                        begin
                            state_q <= ST_DEEP;
                            deep_q  <= 1'b1;
                        end
                        else if (wdata[`CMD_LIGHT_BIT])
                        begin
                            state_q <= ST_LIGHT;
                            deep_q  <= 1'b0;
                        end
                    end
                ST_LIGHT:
                    if (light_wake)
                    begin
                        state_q       <= ST_WAKE;
                        wake_cnt_q    <= 12'h000;
                        wake_target_q <= target_d;
                    end
                ST_DEEP:
                    if (pin_wake)
                    begin
                        state_q       <= ST_WAKE;
                        wake_cnt_q    <= 12'h000;
                        wake_target_q <= target_d;
                    end
                ST_WAKE:
                    if (lrc_rise)
                    begin
                        if (wake_cnt_q == wake_target_q - 12'd1)
                        begin
                            state_q <= ST_RUN;
                            deep_q  <= 1'b0;
                        end
                        else
                            wake_cnt_q <= wake_cnt_q + 12'd1;
                    end
                default:
                    state_q <= ST_RUN;
            endcase
        end
    end

    // Deep sleep stops every oscillator; the wake counter needs the low-speed one back
    assign low_speed_rc_osc_en     = ~(state_q == ST_DEEP);
    assign high_speed_rc_osc_en    = ~deep_q;
    assign external_crystal_osc_en = ~deep_q;
    assign sys_clk_en              = (state_q == ST_RUN);
    assign core_halt               = (state_q != ST_RUN);
    assign program_memory_power    = (state_q == ST_RUN) || (state_q == ST_WAKE);
    assign sram_clear              = sram_clr_q;
    assign core_restart            = any_rst_q;
    assign low_voltage_reset_level = LOW_VOLTAGE_LEVEL_SEL[2:0];

    genvar i;
    wire [NP-1:0] pu_w;
    wire [NP-1:0] pd_w;
    generate
        for (i = 0; i < NP; i = i + 1)
        begin : g_pin
            // Pulls act only on inputs; a pin driving low never fights a pull
            assign pu_w[i] = ~dir_q[i] & pu_q[i];
            assign pd_w[i] = ~dir_q[i] & pd_q[i];
        end
    endgenerate

    assign porta_out = data_q[PINS_A-1:0];
    assign porta_oe  = dir_q[PINS_A-1:0];
    assign porta_pu  = pu_w[PINS_A-1:0];
    assign porta_pd  = pd_w[PINS_A-1:0];
    assign portb_out = data_q[NP-1:PINS_A];
    assign portb_oe  = dir_q[NP-1:PINS_A];
    assign portb_pu  = pu_w[NP-1:PINS_A];
    assign portb_pd  = pd_w[NP-1:PINS_A];

    wire [NP-1:0] readback = (dir_q & data_q) | (~dir_q & pin_stable_q);

    always @*
    begin
        rd_d = 8'h00;
        case (addr)
            `REG_MISC_CTRL:    rd_d = misc_q;
            `REG_CMP_CONTROL:  rd_d = cmp_ctl_q;
            `REG_CMP_SELECT:   rd_d = cmp_sel_q;
            `REG_PORTA_DATA:   rd_d[PINS_A-1:0] = readback[PINS_A-1:0];
            `REG_PORTA_DIR:    rd_d[PINS_A-1:0] = dir_q[PINS_A-1:0];
            `REG_PORTA_PULLUP: rd_d[PINS_A-1:0] = pu_q[PINS_A-1:0];
            `REG_PORTA_PULLDN: rd_d[PINS_A-1:0] = pd_q[PINS_A-1:0];
            `REG_PORTA_DIEN:   rd_d[PINS_A-1:0] = dien_q[PINS_A-1:0];
            `REG_PORTB_DATA:   rd_d[PINS_B-1:0] = readback[NP-1:PINS_A];
            `REG_PORTB_DIR:    rd_d[PINS_B-1:0] = dir_q[NP-1:PINS_A];
            `REG_PORTB_PULLUP: rd_d[PINS_B-1:0] = pu_q[NP-1:PINS_A];
            `REG_PORTB_PULLDN: rd_d[PINS_B-1:0] = pd_q[NP-1:PINS_A];
            `REG_PORTB_DIEN:   rd_d[PINS_B-1:0] = dien_q[NP-1:PINS_A];
            `REG_POWER_STATUS: rd_d = {5'h00, fast_sel, state_q};
            default:           rd_d = 8'h00;
        endcase
    end

    always @(posedge clk)
    begin
        if (rst)
            rdata <= 8'h00;
        else if (ce)
            rdata <= rd ? rd_d : 8'h00;
    end
endmodule // wakeup_ctrl
`default_nettype wire

/* File: wakeup_ctrl_assertions.sv */
/*
 Port-level checker for the sleep, wake-up and pin controller.
 Assumes the single clk domain with synchronous active-high rst.
*/
`timescale 1ns/1ps
`default_nettype none
module wakeup_ctrl_assertions #(
    parameter PINS_A = 8,
    parameter PINS_B = 8,
    parameter LOW_VOLTAGE_LEVEL_SEL = 3
) (
    // Clock, reset and register port
    input wire logic              clk,
    input wire logic              rst,
    input wire logic              ce,
    input wire logic [3:0]        addr,
    input wire logic              rd,
    input wire logic [7:0]        rdata,
    // Reset causes and low-voltage trip level
    input wire logic              ext_reset_cause,
    input wire logic              watchdog_reset_cause,
    input wire logic              power_on_cause,
    input wire logic [2:0]        low_voltage_reset_level,
    // Power controls
    input wire logic              low_speed_rc_osc_en,
    input wire logic              high_speed_rc_osc_en,
    input wire logic              external_crystal_osc_en,
    input wire logic              sys_clk_en,
    input wire logic              core_halt,
    input wire logic              program_memory_power,
    input wire logic              sram_clear,
    input wire logic              core_restart,
    // Pins
    input wire logic [PINS_A-1:0] porta_oe,
    input wire logic [PINS_A-1:0] porta_pu,
    input wire logic [PINS_A-1:0] porta_pd,
    input wire logic [PINS_B-1:0] portb_oe,
    input wire logic [PINS_B-1:0] portb_pu,
    input wire logic [PINS_B-1:0] portb_pd
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_deep_osc_off: assert property (!low_speed_rc_osc_en |-> !high_speed_rc_osc_en
        && !external_crystal_osc_en && !sys_clk_en) else $error("oscillator on in deep sleep");
    a_run_osc_on: assert property (sys_clk_en |-> low_speed_rc_osc_en && high_speed_rc_osc_en)
        else $error("oscillator off while running");
    a_halt_inverse: assert property (core_halt == !sys_clk_en)
        else $error("halt disagrees with clock gate");
    a_mem_power: assert property (!program_memory_power |-> !sys_clk_en)
        else $error("running without program memory");
    a_pulls_off_a: assert property ((porta_oe & (porta_pu | porta_pd)) == '0)
        else $error("port a pull on driven pin");
    a_pulls_off_b: assert property ((portb_oe & (portb_pu | portb_pd)) == '0)
        else $error("port b pull on driven pin");
    a_read_idle: assert property (ce && !rd |=> rdata == 8'h00)
        else $error("read data outside read slot");
    a_unmapped_rd: assert property (ce && rd && addr == 4'hf |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    a_restart_cause: assert property (ce && (ext_reset_cause || watchdog_reset_cause)
        |=> core_restart) else $error("no restart after reset cause");
    a_sram_keep: assert property (ce && !power_on_cause |=> !sram_clear)
        else $error("sram cleared without power on");
    a_trip_level: assert property (low_voltage_reset_level
        == LOW_VOLTAGE_LEVEL_SEL[2:0]) else $error("trip level not the option");
    a_wake_not_early: assert property ($fell(sys_clk_en) |=> !sys_clk_en [*8])
        else $error("clock back too soon");
endmodule // wakeup_ctrl_assertions

bind wakeup_ctrl wakeup_ctrl_assertions #(.PINS_A(PINS_A), .PINS_B(PINS_B),
    .LOW_VOLTAGE_LEVEL_SEL(LOW_VOLTAGE_LEVEL_SEL)) i_chk (
    .clk(clk), .rst(rst), .ce(ce), .addr(addr), .rd(rd), .rdata(rdata),
    .ext_reset_cause(ext_reset_cause), .watchdog_reset_cause(watchdog_reset_cause),
    .power_on_cause(power_on_cause), .low_voltage_reset_level(low_voltage_reset_level),
    .low_speed_rc_osc_en(low_speed_rc_osc_en), .high_speed_rc_osc_en(high_speed_rc_osc_en),
    .external_crystal_osc_en(external_crystal_osc_en), .sys_clk_en(sys_clk_en),
    .core_halt(core_halt), .program_memory_power(program_memory_power),
    .sram_clear(sram_clear), .core_restart(core_restart),
    .porta_oe(porta_oe), .porta_pu(porta_pu), .porta_pd(porta_pd),
    .portb_oe(portb_oe), .portb_pu(portb_pu), .portb_pd(portb_pd));
`default_nettype wire

/* File: pin_board.sv */
/*
 Board model of one port: pads resolved from the device drive, pulls and board drivers.
 Assumes board drive beats a pull; an undriven unpulled pad toggles each cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_board #(
    parameter W = 8
) (
    // Clock
    input  wire logic         clk,
    // Device side
    input  wire logic [W-1:0] out,
    input  wire logic [W-1:0] oe,
    input  wire logic [W-1:0] pu,
    input  wire logic [W-1:0] pd,
    // Board side
    input  wire logic [W-1:0] drv_val,
    input  wire logic [W-1:0] drv_en,
    output var  logic [W-1:0] pad
);
    logic [W-1:0] last_q = '0;
    always_ff @(posedge clk) last_q <= pad;
    always_comb
        for (int i = 0; i < W; i++)
            pad[i] = oe[i] ? out[i] : drv_en[i] ? drv_val[i] : pu[i] ? 1'b1 : pd[i] ? 1'b0 : ~last_q[i];
endmodule // pin_board
`default_nettype wire

/* File: tb_wakeup_ctrl.sv */
/*
 Self-checking bench for the sleep, wake-up and pin controller.
 Assumes a 25 MHz clk and a gated 210 ns low-speed clock from the bench.
*/
`timescale 1ns/1ps
`default_nettype none
`include "wakeup_ctrl_regs.vh"
`define CHECK(nm, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb_wakeup_ctrl;
    logic       clk = 0, rst = 1, ce = 1, wr = 0, rd = 0, lrc = 0, fboot = 0;
    logic       tmr = 0, cmp = 0, ext_c = 0, wd_c = 0, por_c = 0, lv_c = 0;
    logic [3:0] addr = 0;
    logic [7:0] wdata = 0, rdata, porta_in, porta_out, porta_oe, porta_pu, porta_pd;
    logic [7:0] portb_in, portb_out, portb_oe, portb_pu, portb_pd, drv_a = 8'ha0, drv_b = 8'h00;
    logic [2:0] lvl;
    logic       ls_en, hs_en, xo_en, sys_en, halt, pm_pwr, sram_clr, restart;
    integer     miscompares = 0, checked = 0, cycles = 0;

    wakeup_ctrl i_dut (.clk(clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .fast_boot_opt(fboot), .ext_reset_cause(ext_c),
        .watchdog_reset_cause(wd_c), .power_on_cause(por_c), .low_voltage_reset(lv_c),
        .low_voltage_reset_level(lvl), .timer_event(tmr), .cmp_event(cmp), .lrc_clk_in(lrc),
        .low_speed_rc_osc_en(ls_en), .high_speed_rc_osc_en(hs_en),
        .external_crystal_osc_en(xo_en), .sys_clk_en(sys_en), .core_halt(halt),
        .program_memory_power(pm_pwr), .sram_clear(sram_clr), .core_restart(restart),
        .porta_in(porta_in), .porta_out(porta_out), .porta_oe(porta_oe),
        .porta_pu(porta_pu), .porta_pd(porta_pd), .portb_in(portb_in),
        .portb_out(portb_out), .portb_oe(portb_oe), .portb_pu(portb_pu),
        .portb_pd(portb_pd));
    pin_board i_board_a (.clk(clk), .out(porta_out), .oe(porta_oe), .pu(porta_pu),
        .pd(porta_pd), .drv_val(drv_a), .drv_en(8'hff), .pad(porta_in));
    pin_board i_board_b (.clk(clk), .out(portb_out), .oe(portb_oe), .pu(portb_pu),
        .pd(portb_pd), .drv_val(drv_b), .drv_en(8'hff), .pad(portb_in));

    always #20 clk = ~clk;
    // Low-speed clock stands still while the device has it switched off
    always #105 if (ls_en === 1'b1) lrc = ~lrc;
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            miscompares++;
            print_verdict;
        end
    end

    task print_verdict;
        if (miscompares == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task reg_wr(input [3:0] a, input [7:0] d);
        @(posedge clk);
        wr <= 1; addr <= a; wdata <= d;
        @(posedge clk);
        wr <= 0;
    endtask
    task reg_rd(input [3:0] a, input [7:0] e, input string nm);
        @(posedge clk);
        rd <= 1; addr <= a;
        @(posedge clk);
        rd <= 0;
        #1 `CHECK(nm, e, rdata)
    endtask
    task sleep(input [7:0] cmd);
        reg_wr(`REG_POWER_CMD, cmd);
        repeat (3) @(posedge clk);
    endtask
    // Wake source: 0 pin toggle on port B bit 3, 1 timer, 2 comparator
    task wake(input integer src, input integer lo, input integer hi);
        integer n;
        n = 0;
        if (src == 0) drv_b <= drv_b ^ 8'h08;
        else if (src == 1) tmr <= 1;
        else cmp <= 1;
        @(posedge clk);
        tmr <= 0; cmp <= 0;
        while (sys_en !== 1'b1 && n < 20000)
        begin
            @(posedge clk);
            n++;
        end
        `CHECK("wake_delay", 1'b1, n >= lo && n <= hi)
    endtask

    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 0;
        reg_rd(`REG_POWER_STATUS, 8'h00, "status");
        reg_rd(`REG_PORTA_DIEN, `DIEN_RESET, "dien_a");
        reg_rd(4'hf, 8'h00, "unmapped");
        `CHECK("trip_level", 3'd3, lvl)
        reg_wr(`REG_PORTA_DIR, 8'h0f);
        reg_wr(`REG_PORTA_DATA, 8'h05);
        reg_wr(`REG_PORTA_PULLUP, 8'hff);
        reg_wr(`REG_PORTA_PULLDN, 8'hf0);
        #1 `CHECK("porta_oe", 8'h0f, porta_oe)
        `CHECK("porta_out", 8'h05, porta_out)
        `CHECK("porta_pu", 8'hf0, porta_pu)
        `CHECK("porta_pd", 8'hf0, porta_pd)
        reg_wr(`REG_PORTB_DIR, 8'h80);
        reg_wr(`REG_PORTB_DATA, 8'h80);
        #1 `CHECK("portb_drive", 16'h8080, {portb_oe, portb_out})
        repeat (4) @(posedge clk);
        reg_rd(`REG_PORTA_DATA, 8'ha5, "porta_read");
        reg_rd(`REG_PORTB_DATA, 8'h80, "portb_read");
        reg_wr(`REG_PORTA_DIEN, 8'hef);
        reg_wr(`REG_PORTB_DIEN, 8'hff);
        reg_wr(`REG_MISC_CTRL, 8'h20);
        reg_wr(`REG_CMP_CONTROL, 8'h80);
        sleep(8'h03);
        `CHECK("ls_en", 1'b0, ls_en)
        `CHECK("hs_xo_en", 2'b00, {hs_en, xo_en})
        `CHECK("pm_pwr", 1'b0, pm_pwr)
        reg_wr(`REG_MISC_CTRL, 8'h00);
        tmr <= 1; cmp <= 1; drv_a <= 8'hb0;
        @(posedge clk);
        tmr <= 0; cmp <= 0;
        repeat (20) @(posedge clk);
        `CHECK("deep_stays", 1'b0, sys_en)
        wake(0, 225, 275);
        // A write while the clock enable is low must leave the register alone
        ce <= 0;
        reg_wr(`REG_MISC_CTRL, 8'h00);
        ce <= 1;
        reg_rd(`REG_MISC_CTRL, 8'h20, "misc_kept");
        reg_rd(`REG_PORTA_DIR, 8'h0f, "dir_kept");
        `CHECK("no_restart", 1'b0, restart)
        sleep(8'h01);
        `CHECK("light_osc", 3'b110, {ls_en, hs_en, sys_en})
        `CHECK("light_pm", 1'b0, pm_pwr)
        cmp <= 1;
        @(posedge clk);
        cmp <= 0;
        repeat (20) @(posedge clk);
        `CHECK("cmp_masked", 1'b0, sys_en)
        wake(1, 225, 275);
        reg_wr(`REG_CMP_SELECT, 8'h40);
        sleep(8'h01);
        wake(2, 225, 275);
        sleep(8'h01);
        wake(0, 225, 275);
        reg_wr(`REG_MISC_CTRL, 8'h00);
        reg_wr(`REG_CMP_CONTROL, 8'h00);
        fboot <= 1;
        sleep(8'h02);
        wake(0, 225, 275);
        fboot <= 0;
        sleep(8'h02);
        wake(0, 15650, 15850);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk);
            {lv_c, por_c, wd_c, ext_c} <= 4'b0001 << i;
            @(posedge clk);
            {lv_c, por_c, wd_c, ext_c} <= 4'b0000;
            #1 `CHECK("restart", 1'b1, restart)
            `CHECK("sram_clr", i == 2, sram_clr)
            repeat (2) @(posedge clk);
            reg_rd(`REG_PORTA_DIR, `PORT_RESET, "dir_reload");
        end
        print_verdict;
    end
endmodule // tb_wakeup_ctrl
`default_nettype wire
